// >>> hw/ccc_pkg.sv
// Constants shared by the cache capability and configuration front end.
// Assumes a 32-bit register port with word-aligned byte addresses.
package ccc_pkg;
  localparam int          CCC_AW        = 8;
  localparam logic [7:0]  CCC_OFF_CAP   = 8'h00;
  localparam logic [7:0]  CCC_OFF_CFG   = 8'h04;
  localparam logic [7:0]  CCC_OFF_CTRL  = 8'h08;
  localparam logic [7:0]  CCC_OFF_STAT  = 8'h0C;
  // Capability field positions.
  localparam int          CCC_LINE_LSB  = 11;
  localparam int          CCC_CAPY_LSB  = 8;
  localparam int          CCC_LOCK_BIT  = 7;
  localparam int          CCC_ASSOC_LSB = 5;
  localparam int          CCC_RR_BIT    = 4;
  localparam int          CCC_LRU_BIT   = 3;
  localparam int          CCC_RAND_BIT  = 2;
  localparam int          CCC_GATE_BIT  = 1;
  localparam int          CCC_DBG_BIT   = 0;
  localparam logic [2:0]  CCC_LINE_16B  = 3'h2;
  localparam logic [2:0]  CCC_CAPY_4KB  = 3'h2;
  localparam logic [1:0]  CCC_ASSOC_4W  = 2'h2;
  // Configuration field positions and reset.
  localparam int          CCC_SEL_LSB   = 4;
  localparam int          CCC_DOFF_BIT  = 2;
  localparam int          CCC_IOFF_BIT  = 1;
  localparam int          CCC_ON_BIT    = 0;
  localparam logic [2:0]  CCC_SEL_RST   = 3'h2;
  localparam logic [2:0]  CCC_SEL_RSVD  = 3'h7;
  localparam logic [31:0] CCC_CFG_MASK  = 32'h00000076;
  localparam logic [31:0] CCC_CFG_RST   = 32'h00000020;
  localparam logic [31:0] CCC_CAP_RST   = 32'h000012D2;
endpackage

// >>> hw/ccc_cap_word.sv
// Builds the constant capability word from the feature parameters.
// Assumes parameters stay within their documented codes.
`timescale 1ns/1ps
module ccc_cap_word
  import ccc_pkg::*;
#(
  parameter logic [2:0] LINE_CODE  = CCC_LINE_16B,
  parameter logic [2:0] CAPY_CODE  = CCC_CAPY_4KB,
  parameter logic [1:0] ASSOC_CODE = CCC_ASSOC_4W,
  parameter bit         LOCK_SUP   = 1'b1,
  parameter bit         RR_SUP     = 1'b1,
  parameter bit         LRU_SUP    = 1'b0,
  parameter bit         RAND_SUP   = 1'b0,
  parameter bit         GATE_SUP   = 1'b1,
  parameter bit         DBG_OK     = 1'b0
)(
  output wire logic [31:0] capWord
);
  // Unused upper bits stay zero.
  assign capWord = {18'h00000, LINE_CODE, CAPY_CODE, LOCK_SUP, ASSOC_CODE,
                    RR_SUP, LRU_SUP, RAND_SUP, GATE_SUP, DBG_OK};
endmodule // ccc_cap_word

// >>> hw/ccc_route.sv
// Steers each core access either into the cache or straight to memory.
// Assumes the class flag is valid in the same cycle as the request.
`timescale 1ns/1ps
module ccc_route (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic accReq,
  input  wire logic classOff,
  input  wire logic unitOn,
  output logic      toCache,
  output logic      toMemory
);
  wire useCache = unitOn && !classOff;

  // Registered so the top drives flops only.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      toCache  <= 1'b0;
      toMemory <= 1'b0;
    end
    else
    begin
      toCache  <= accReq && useCache;
      toMemory <= accReq && !useCache;
    end
  end
endmodule // ccc_route

// >>> hw/ccc_regs.sv
// Capability, configuration and enable registers of the cache unit.
// Assumes a single-cycle strobe port; reads answer one cycle later.
// Operation
// [RULE_01] Line size code at bits 13:11
// [RULE_02] Capacity code at bits 10:8
// [RULE_03] Bit 7 reports lock support
// [RULE_04] Associativity code at bits 6:5
// [RULE_05] Bit 4 reports round-robin support
// [RULE_06] Bit 3 reports LRU support
// [RULE_07] Bit 2 reports random replacement support
// [RULE_08] Bit 1 reports clock gating support
// [RULE_09] Bit 0 reports debug port access
// [RULE_10] Software capacity select, bits 6:4, reset 4KB
// [RULE_11] Config bit 2 turns data caching off
// [RULE_12] Config bit 1 turns instruction caching off
// [RULE_13] Control bit 0 turns unit on/off
// [RULE_14] Software disables and checks status before debug
// [RULE_15] Reserved bits ignored, read zero
// [RULE_16] Disabled class bypasses cache to memory
`timescale 1ns/1ps
module ccc_regs
  import ccc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [CCC_AW-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [31:0]            regRdata,
  input  wire logic              instrReq,
  input  wire logic              dataReq,
  output logic                   instrToCache,
  output logic                   instrToMemory,
  output logic                   dataToCache,
  output logic                   dataToMemory,
  output logic [2:0]             sw_capacity_select,
  output logic                   cache_active_flag
);
  logic [2:0]  swSel;
  logic        data_cache_off;
  logic        instr_cache_off;
  logic        cache_on;
  logic [31:0] capWord;

  // Fixed capability word.
  ccc_cap_word u_cap (
    .capWord (capWord)  // see [RULE_01] see [RULE_02] see [RULE_03]
  );                    // see [RULE_04] see [RULE_05] see [RULE_06]
                        // see [RULE_07] see [RULE_08] see [RULE_09]

  // Address decode.
  wire hitCfg  = regAddr == CCC_OFF_CFG;
  wire hitCtrl = regAddr == CCC_OFF_CTRL;
  wire wrCfg   = regWrite && hitCfg;
  wire wrCtrl  = regWrite && hitCtrl;
  wire [2:0] wSel = regWdata[CCC_SEL_LSB +: 3];
  // The reserved select code is refused so the size stays legal.
  wire selOk = wSel != CCC_SEL_RSVD;

  wire [31:0] cfgWord = {25'h0000000, swSel, 1'b0, data_cache_off,
                         instr_cache_off, 1'b0};
  // Control reads zero since it is write-only; unmapped reads zero.
  wire [31:0] next_rdata =
    (regAddr == CCC_OFF_CAP)  ? capWord :          // see [RULE_15]
    hitCfg                    ? (cfgWord & CCC_CFG_MASK) :
    (regAddr == CCC_OFF_STAT) ? {31'h00000000, cache_active_flag} :
                                32'h00000000;

  // Configuration register; writes to the capability word go nowhere.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      swSel           <= CCC_SEL_RST;                 // see [RULE_10]
      data_cache_off  <= 1'b0;
      instr_cache_off <= 1'b0;
    end
    else if (wrCfg)
    begin
      if (selOk)
        swSel <= wSel;                                // see [RULE_10]
      data_cache_off  <= regWdata[CCC_DOFF_BIT];      // see [RULE_11]
      instr_cache_off <= regWdata[CCC_IOFF_BIT];      // see [RULE_12]
    end
  end

  // Enable bit and its status mirror, which lags by one cycle.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cache_on          <= 1'b0;
      cache_active_flag <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        cache_on <= regWdata[CCC_ON_BIT];             // see [RULE_13]
      cache_active_flag <= cache_on;                  // see [RULE_14]
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      regRdata <= 32'h00000000;
    else
      regRdata <= regRead ? next_rdata : 32'h00000000;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sw_capacity_select <= CCC_SEL_RST;
    else
      sw_capacity_select <= swSel;
  end

  // Per-class routing: off class or off unit goes to memory.
  ccc_route u_iroute (
    .clock    (clock),
    .rst_n    (rst_n),
    .accReq   (instrReq),
    .classOff (instr_cache_off),
    .unitOn   (cache_on),
    .toCache  (instrToCache),
    .toMemory (instrToMemory)                         // see [RULE_16]
  );
  ccc_route u_droute (
    .clock    (clock),
    .rst_n    (rst_n),
    .accReq   (dataReq),
    .classOff (data_cache_off),
    .unitOn   (cache_on),
    .toCache  (dataToCache),
    .toMemory (dataToMemory)                          // see [RULE_16]
  );

  // Checks. A read strobe is answered at the next edge, so every read
  // property looks one cycle after its sequence. The capability checks
  // compare against the documented reset word and field codes rather than the feature
  // parameters, so a wrong override of the feature module shows up here.
  sequence s_readCap;
    regRead && regAddr == CCC_OFF_CAP;
  endsequence
  sequence s_readCfg;
    regRead && hitCfg;
  endsequence
  sequence s_readCtrl;
    regRead && hitCtrl;
  endsequence
  sequence s_writeCap;
    regWrite && regAddr == CCC_OFF_CAP;
  endsequence
  sequence s_ctrlWrite;
    wrCtrl;
  endsequence
  sequence s_instrOff;
    instrReq && (!cache_on || instr_cache_off);
  endsequence
  sequence s_dataOff;
    dataReq && (!cache_on || data_cache_off);
  endsequence
  sequence s_instrOn;
    instrReq && cache_on && !instr_cache_off;
  endsequence
  sequence s_dataOn;
    dataReq && cache_on && !data_cache_off;
  endsequence

  // Capability fields, one property per documented field.
  AST_CAP_LINE: assert property ( // see [RULE_01]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_LINE_LSB +: 3] == CCC_LINE_16B)
    else $error("line size code wrong");
  AST_CAP_SIZE: assert property ( // see [RULE_02]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_CAPY_LSB +: 3] == CCC_CAPY_4KB)
    else $error("capacity code wrong");
  AST_CAP_LOCK: assert property ( // see [RULE_03]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_LOCK_BIT] == CCC_CAP_RST[CCC_LOCK_BIT])
    else $error("lock support bit wrong");
  AST_CAP_ASSOC: assert property ( // see [RULE_04]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_ASSOC_LSB +: 2] == CCC_ASSOC_4W)
    else $error("associativity wrong");
  AST_CAP_RR: assert property ( // see [RULE_05]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_RR_BIT] == CCC_CAP_RST[CCC_RR_BIT])
    else $error("round robin support bit wrong");
  AST_CAP_LRU: assert property ( // see [RULE_06]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_LRU_BIT] == CCC_CAP_RST[CCC_LRU_BIT])
    else $error("lru support bit wrong");
  AST_CAP_RAND: assert property ( // see [RULE_07]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_RAND_BIT] == CCC_CAP_RST[CCC_RAND_BIT])
    else $error("random support bit wrong");
  AST_CAP_GATE: assert property ( // see [RULE_08]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_GATE_BIT] == CCC_CAP_RST[CCC_GATE_BIT])
    else $error("gating support bit wrong");
  AST_CAP_DBG: assert property ( // see [RULE_09]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata[CCC_DBG_BIT] == CCC_CAP_RST[CCC_DBG_BIT])
    else $error("debug port bit wrong");

  // The whole word catches stray ones in the unused upper bits.
  AST_CAP_READ: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    s_readCap |=> regRdata == CCC_CAP_RST)
    else $error("capability word wrong");
  // Software may try to write the read-only word; nothing may move.
  AST_CAP_WRITE: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    s_writeCap |=> $stable(swSel) && $stable(cache_on) &&
                   $stable(data_cache_off) && $stable(instr_cache_off))
    else $error("capability write changed state");
  AST_CFG_RESERVED: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    s_readCfg |=> (regRdata & ~CCC_CFG_MASK) == 32'h0)
    else $error("reserved config bits nonzero");
  AST_CTRL_READ: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    s_readCtrl |=> regRdata == 32'h0)
    else $error("control word not read as zero");

  // Configuration fields.
  AST_SEL_WRITE: assert property ( // see [RULE_10]
    @(posedge clock) disable iff (!rst_n)
    wrCfg && selOk |=> swSel == $past(wSel))
    else $error("capacity select not stored");
  AST_SEL_RSVD: assert property ( // see [RULE_10]
    @(posedge clock) disable iff (!rst_n)
    wrCfg && !selOk |=> $stable(swSel))
    else $error("reserved capacity code stored");
  AST_DOFF: assert property ( // see [RULE_11]
    @(posedge clock) disable iff (!rst_n)
    wrCfg |=> data_cache_off == $past(regWdata[CCC_DOFF_BIT]))
    else $error("data off bit not stored");
  AST_IOFF: assert property ( // see [RULE_12]
    @(posedge clock) disable iff (!rst_n)
    wrCfg |=> instr_cache_off == $past(regWdata[CCC_IOFF_BIT]))
    else $error("instr off bit not stored");

  // Enable takes effect one edge after the write, the status one edge
  // later; software polling the status must allow for that lag.
  AST_ENABLE: assert property ( // see [RULE_13]
    @(posedge clock) disable iff (!rst_n)
    s_ctrlWrite |=> cache_on == $past(regWdata[CCC_ON_BIT])
    ##1 cache_active_flag == $past(regWdata[CCC_ON_BIT], 2))
    else $error("status does not follow enable");

  // Routing: each request leaves on exactly one side, one cycle later.
  AST_IBYPASS: assert property ( // see [RULE_16]
    @(posedge clock) disable iff (!rst_n)
    s_instrOff |=> instrToMemory && !instrToCache)
    else $error("disabled instr access not bypassed");
  AST_BYPASS: assert property ( // see [RULE_16]
    @(posedge clock) disable iff (!rst_n)
    s_dataOff |=> dataToMemory && !dataToCache)
    else $error("disabled data access not bypassed");
  AST_ICACHED: assert property ( // see [RULE_12]
    @(posedge clock) disable iff (!rst_n)
    s_instrOn |=> instrToCache && !instrToMemory)
    else $error("enabled instr access not cached");
  AST_DCACHED: assert property ( // see [RULE_11]
    @(posedge clock) disable iff (!rst_n)
    s_dataOn |=> dataToCache && !dataToMemory)
    else $error("enabled data access not cached");

  // Read data outside its slot must be zero so that a bus OR-tree works.
  AST_RD_ONE: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    !regRead |=> regRdata == 32'h0)
    else $error("read data outside read slot");
endmodule // ccc_regs

// >>> verification/ccc_core_model.sv
// Core model that issues instruction and data requests.
// Assumes go stays low until the register front end leaves reset.
`timescale 1ns/1ps
module ccc_core_model (
  input  wire logic clock,
  input  wire logic go,
  output logic      instrReq,
  output logic      dataReq
);
  logic [31:0] state = 32'h00402A4C;
  initial {instrReq, dataReq} = 2'b00;
  // A real core may request every cycle, so back-to-back requests come here.
  always @(posedge clock)
  begin
    state    <= {state[30:0], state[31] ^ state[21] ^ state[1] ^ state[0]};
    instrReq <= go & state[3];
    dataReq  <= go & state[7];
  end
endmodule // ccc_core_model

// >>> verification/test_ccc_regs.sv
// Self-checking bench for the cache capability and configuration registers.
// Assumes the core model drives requests; the register port is driven here.
`timescale 1ns/1ps
module test_ccc_regs import ccc_pkg::*;;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic [CCC_AW-1:0] regAddr = 8'h00;
  logic [31:0]       regWdata = 32'h0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic              go = 1'b0;
  logic              en = 1'b0;
  logic              act = 1'b0;
  logic [31:0]       cfg = CCC_CFG_RST;
  logic [31:0]       lfsr = 32'h00402A4C;
  logic [31:0]       regRdata, e;
  logic              instrReq, dataReq, iC, iM, dC, dM, flag;
  logic [2:0]        sel;
  logic [2:0]        selExp = CCC_SEL_RST;
  logic [3:0]        rt;
  logic [31:0]       rdQ[$];
  logic [3:0]        rtQ[$];
  int                mismatches = 0;
  int                samples_checked = 0;
  always #2 clock = ~clock;
  ccc_core_model core (.clock(clock), .go(go), .instrReq(instrReq),
    .dataReq(dataReq));
  ccc_regs dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .instrReq(instrReq), .dataReq(dataReq),
    .instrToCache(iC), .instrToMemory(iM), .dataToCache(dC),
    .dataToMemory(dM), .sw_capacity_select(sel), .cache_active_flag(flag));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  // One strobe per edge; the next call or the final idle releases it.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clock);
    regWrite <= w;
    regRead  <= ~w;
    regAddr  <= a;
    regWdata <= d;
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Notes what each request taken at this edge must produce one cycle on.
  always @(posedge clock)
  if (!rst_n)
  begin
    en = 1'b0;
    act = 1'b0;
    cfg = CCC_CFG_RST;
    selExp = CCC_SEL_RST;
  end
  else
  begin
    rtQ.push_back({instrReq & en & ~cfg[1], instrReq & ~(en & ~cfg[1]),
                   dataReq & en & ~cfg[2], dataReq & ~(en & ~cfg[2])});
    if (regRead)
      rdQ.push_back(regAddr == CCC_OFF_CAP ? CCC_CAP_RST :
                    regAddr == CCC_OFF_CFG ? cfg :
                    regAddr == CCC_OFF_STAT ? {31'h0, act} : 32'h0);
    act = en;
    // The select output is a second flop, so it trails the config by one.
    selExp = cfg[6:4];
    if (regWrite && regAddr == CCC_OFF_CTRL)
      en = regWdata[0];
    // A reserved select code leaves the old capacity in force.
    if (regWrite && regAddr == CCC_OFF_CFG)
      cfg = {25'h0, regWdata[6:4] == 3'h7 ? cfg[6:4] : regWdata[6:4],
             1'b0, regWdata[2:1], 1'b0};
  end
  // Outputs are settled by the falling edge, so compare them there.
  always @(negedge clock)
  begin
    check("flag", {31'h0, flag}, {31'h0, act});
    check("select", {29'h0, sel}, {29'h0, selExp});
    if (rtQ.size() > 0)
    begin
      rt = rtQ.pop_front();
      check("instr route", {iC, iM}, rt[3:2]);
      check("data route", {dC, dM}, rt[1:0]);
    end
    e = (rdQ.size() > 0) ? rdQ.pop_front() : 32'h0;
    check("rdata hi", regRdata[31:14], e[31:14]);
    check("rdata line", regRdata[13:11], e[13:11]);
    check("rdata size", regRdata[10:8], e[10:8]);
    check("rdata lock", regRdata[7], e[7]);
    check("rdata assoc", regRdata[6:5], e[6:5]);
    check("rdata rr", regRdata[4], e[4]);
    check("rdata lru", regRdata[3], e[3]);
    check("rdata rand", regRdata[2], e[2]);
    check("rdata gate", regRdata[1], e[1]);
    check("rdata debug", regRdata[0], e[0]);
  end
  initial
  begin
    #4000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    go    <= 1'b1;
    access(1'b0, CCC_OFF_CAP, 32'h0);
    access(1'b0, CCC_OFF_CFG, 32'h0);
    access(1'b1, CCC_OFF_CAP, 32'hFFFFFFFF);
    access(1'b0, CCC_OFF_CAP, 32'h0);
    access(1'b1, CCC_OFF_CTRL, 32'h1);
    access(1'b0, CCC_OFF_STAT, 32'h0);
    access(1'b0, CCC_OFF_STAT, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      lfsr = step(lfsr);
      access(1'b1, CCC_OFF_CFG, lfsr);
      access(1'b0, CCC_OFF_CFG, 32'h0);
      access(lfsr[9], lfsr[8] ? CCC_OFF_CTRL : 8'h40, lfsr);
      access(1'b0, {4'h0, lfsr[11:10], 2'b00}, 32'h0);
    end
    access(1'b1, CCC_OFF_CTRL, 32'h0);
    access(1'b0, CCC_OFF_STAT, 32'h0);
    access(1'b0, CCC_OFF_STAT, 32'h0);
    // A second reset while enabled must bring back every default.
    access(1'b1, CCC_OFF_CTRL, 32'h1);
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    rst_n    <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    access(1'b0, CCC_OFF_CFG, 32'h0);
    access(1'b0, CCC_OFF_STAT, 32'h0);
    @(posedge clock);
    regRead <= 1'b0;
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule // test_ccc_regs
